// ---- rtl/trig_seq_pkg.sv ----
// Purpose: shared constants, register map and carrier types of the
//          trigger sequencer
// Assumes: 32-bit classic Wishbone, byte addressed, word aligned
// Notes:   every offset below is a byte address
package trig_seq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int NUM_STATES  = 16;
  localparam int STATE_W     = 4;
  localparam int NUM_BLOCKS  = 3;
  localparam int NUM_CNT     = 4;
  localparam int CNT_W       = 16;
  localparam int NUM_FLAGS   = 4;
  localparam int MAX_CMP     = 8;
  localparam int MAX_PROBE_W = 16;
  localparam int MAX_CMP_PER_PROBE = 16;
  localparam int ADR_W       = 12;
  localparam int DAT_W       = 32;
  localparam int SEL_W       = 4;
  localparam int PCMP_OP_W   = 4;
  localparam int ACT_W       = 21;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [ADR_W-1:0] CTRL_OFS     = 12'h000;
  localparam logic [ADR_W-1:0] STATUS_OFS   = 12'h004;
  localparam logic [ADR_W-1:0] CNT_VAL_BASE = 12'h010;
  localparam logic [ADR_W-1:0] CNT_CMP_BASE = 12'h020;
  localparam logic [ADR_W-1:0] PCMP_BASE    = 12'h100;
  localparam logic [ADR_W-1:0] PROG_BASE    = 12'h400;

  // field positions
  localparam int CTRL_ARM_BIT   = 0;
  localparam int CTRL_STOP_BIT  = 1;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_FLAG_LSB  = 4;
  localparam int STAT_RUN_BIT   = 8;
  localparam int STAT_TRIG_BIT  = 9;
  localparam int CNTCMP_NE_BIT  = 16;

  // writable bits, everything else reads as zero
  localparam logic [DAT_W-1:0] COND_WMASK   = 32'h33ffffff;
  localparam logic [DAT_W-1:0] ACT_WMASK    = 32'h001fffff;
  localparam logic [DAT_W-1:0] PCMP0_WMASK  = 32'hffffffff;
  localparam logic [DAT_W-1:0] PCMP1_WMASK  = 32'h0000000f;
  localparam logic [DAT_W-1:0] CNTCMP_WMASK = 32'h0001ffff;

  // values after reset
  localparam logic [DAT_W-1:0] MEM_RST      = 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [PCMP_OP_W-1:0] {
    OP_EQ, OP_NE, OP_GT, OP_LT, OP_GE, OP_LE,
    OP_RISE, OP_FALL, OP_ANY, OP_NOEDGE
  } cmp_op_t;

  typedef enum logic [1:0] {BR_ONE, BR_TWO, BR_THREE} branch_t;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ARMED, SEQ_DONE} seq_t;

  typedef struct packed {
    logic [NUM_CNT-1:0]   rstCnt;
    logic [NUM_CNT-1:0]   incCnt;
    logic [NUM_FLAGS-1:0] clrFlag;
    logic [NUM_FLAGS-1:0] setFlag;
    logic                 trig;
    logic [STATE_W-1:0]   target;
  } action_t;

  typedef struct packed {
    logic               cntAnd;
    logic [1:0]         cntSel;
    logic               cntEn;
    logic               probeAnd;
    logic [MAX_CMP-1:0] cmpMask;
  } cond_t;

  typedef struct packed {
    logic [1:0] rsvdHi;
    branch_t    branch;
    logic [1:0] rsvdLo;
    cond_t      cond2;
    cond_t      cond1;
  } cond_word_t;

  typedef struct packed {
    logic [PCMP_OP_W-1:0]   op;
    logic [MAX_PROBE_W-1:0] care;
    logic [MAX_PROBE_W-1:0] value;
  } pcmp_cfg_t;

  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [SEL_W-1:0] sel;
    logic [DAT_W-1:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic             ack;
    logic [DAT_W-1:0] dat;
  } wb_rsp_t;

endpackage

// ---- rtl/probe_comparator.sv ----
// Purpose: one probe comparator, value or edge match
// Assumes: cur and prev are consecutive samples of the same probe
// Notes:   edge modes look at bit 0 only, meant for single-bit probes
module probe_comparator
#(
  parameter int PROBE_W = 8
)(
  input  wire trig_seq_pkg::pcmp_cfg_t cfg,
  input  wire logic [PROBE_W-1:0]      cur,
  input  wire logic [PROBE_W-1:0]      prev,
  output      logic                    match
);
  import trig_seq_pkg::*;

  logic [PROBE_W-1:0] care;
  logic [PROBE_W-1:0] mCur;
  logic [PROBE_W-1:0] mVal;

  ////////////////////////////////////////////////////////////////////////////
  // don't-care bits are forced equal on both sides, so they always match
  always_comb
  begin
    care  = cfg.care[PROBE_W-1:0];
    mCur  = cur & care;
    mVal  = cfg.value[PROBE_W-1:0] & care;
    case (cmp_op_t'(cfg.op))
      OP_EQ:     match = (mCur == mVal);
      OP_NE:     match = (mCur != mVal);
      OP_GT:     match = (mCur >  mVal);
      OP_LT:     match = (mCur <  mVal);
      OP_GE:     match = (mCur >= mVal);
      OP_LE:     match = (mCur <= mVal);
      OP_RISE:   match = ~prev[0] & cur[0];
      OP_FALL:   match = prev[0] & ~cur[0];
      OP_ANY:    match = prev[0] ^ cur[0];
      OP_NOEDGE: match = ~(prev[0] ^ cur[0]);
      default:   match = 1'b0;
    endcase
  end

endmodule

// ---- rtl/trigger_sequencer_fsm.sv ----
// Purpose: programmable trigger sequencer of an embedded_logic_analyzer
// Assumes: probes are synchronous to clk_sys; program loaded over Wishbone
// Notes:   one step per clock; a trigger stops the sequencer until rearmed
// What this block does
// - holds a program of up to sixteen states, each with actions and branch
// - provides four 16-bit event counters for counting or timing
// - counters clear or count up by action; values feed conditions
// - four status flags set or cleared by actions, readable by software
// - a goto action moves to the named target state
// - one-way states go to their single target with no condition
// - two-way states take first block if condition true, else second
// - three-way: first condition wins, then second, else default block
// - probe conditions only in branches; each uses its own comparator
// - each probe has a build-time count of comparators, one to eight, at most eight in all
// - comparators do equal, unequal, greater, less and their inclusive forms
// - constants are probe-wide with zero, one or don't-care per bit
// - single-bit rising edge match: previous zero, current one
// - single-bit falling edge match: previous one, current zero
// - single-bit any-edge and no-edge matches
// - several probe comparisons join by AND or OR into one decision
// - probe terms share one operator; counter term joins by AND or OR
// - each counter has a single comparator shared by the whole program
// - counter conditions compare with equal or not-equal only
module trigger_sequencer_fsm
#(
  parameter int NUM_PROBES    = 4,
  parameter int PROBE_W       = 8,
  parameter int CMP_PER_PROBE = 2
)(
  input  wire logic                               clk_sys,
  input  wire logic                               rstn,
  input  wire trig_seq_pkg::wb_req_t              wbReq,
  output      trig_seq_pkg::wb_rsp_t              wbRsp,
  input  wire logic [NUM_PROBES*PROBE_W-1:0]      probes,
  output      logic                               trigger,
  output      logic [trig_seq_pkg::NUM_FLAGS-1:0] statusFlags,
  output      logic [trig_seq_pkg::STATE_W-1:0]   seqState,
  output      logic                               running,
  output      logic                               triggered
);
  import trig_seq_pkg::*;
  localparam int NUM_CMP = NUM_PROBES * CMP_PER_PROBE;
  ////////////////////////////////////////////////////////////////////////////
  // an 8-bit condition mask caps the total at eight, so even one probe has at most 8
  if (CMP_PER_PROBE < 1 || CMP_PER_PROBE > MAX_CMP_PER_PROBE ||
      NUM_CMP > MAX_CMP || PROBE_W < 1 || PROBE_W > MAX_PROBE_W ||
      NUM_PROBES < 1)
  begin : g_bad_params
    $error("trigger_sequencer_fsm: unsupported parameter values");
  end
  logic [DAT_W-1:0]        condMem        [NUM_STATES];
  logic [DAT_W-1:0]        next_condMem   [NUM_STATES];
  logic [DAT_W-1:0]        actMem         [NUM_STATES][NUM_BLOCKS];
  logic [DAT_W-1:0]        next_actMem    [NUM_STATES][NUM_BLOCKS];
  logic [DAT_W-1:0]        pcmpMem        [MAX_CMP][2];
  logic [DAT_W-1:0]        next_pcmpMem   [MAX_CMP][2];
  logic [DAT_W-1:0]        cntCmpMem      [NUM_CNT];
  logic [DAT_W-1:0]        next_cntCmpMem [NUM_CNT];
  logic [CNT_W-1:0]        counters       [NUM_CNT];
  logic [CNT_W-1:0]        next_counters  [NUM_CNT];
  wb_rsp_t                 next_wbRsp;
  seq_t                    seq;
  seq_t                    next_seq;
  logic [STATE_W-1:0]      next_seqState;
  logic [NUM_FLAGS-1:0]    next_statusFlags;
  logic                    next_trigger;
  logic                    next_running;
  logic                    next_triggered;
  logic [NUM_PROBES*PROBE_W-1:0] probePrev;
  logic                    armCmd;
  logic                    stopCmd;
  logic                    wrEn;
  logic [DAT_W-1:0]        rdWord;
  logic [MAX_CMP-1:0]      cmpHit;
  logic [NUM_CNT-1:0]      cntHit;
  cond_word_t              curCond;
  action_t                 curAct;
  logic [1:0]              blkSel;
  logic                    cond1Hit;
  logic                    cond2Hit;
  logic                    stepEn;
  ////////////////////////////////////////////////////////////////////////////
  // comparators, fixed to their probe at build time
  for (genvar c = 0; c < MAX_CMP; c++)
  begin : g_cmp
    if (c < NUM_CMP)
    begin : g_used
      probe_comparator #(.PROBE_W(PROBE_W)) u_cmp (
        .cfg   (pcmp_cfg_t'({pcmpMem[c][1][PCMP_OP_W-1:0],
                             pcmpMem[c][0]})),
        .cur   (probes[(c / CMP_PER_PROBE) * PROBE_W +: PROBE_W]),
        .prev  (probePrev[(c / CMP_PER_PROBE) * PROBE_W +: PROBE_W]),
        .match (cmpHit[c])
      );
    end
    else
    begin : g_unused
      assign cmpHit[c] = 1'b0;
    end
  end
  // one comparator per counter, equal or not-equal only
  for (genvar k = 0; k < NUM_CNT; k++)
  begin : g_cnt_cmp
    assign cntHit[k] = cntCmpMem[k][CNTCMP_NE_BIT] ?
                       (counters[k] != cntCmpMem[k][CNT_W-1:0]) :
                       (counters[k] == cntCmpMem[k][CNT_W-1:0]);
  end
  ////////////////////////////////////////////////////////////////////////////
  // a condition with no term at all never fires
  function automatic logic evalCond(input cond_t              cd,
                                    input logic [MAX_CMP-1:0] hit,
                                    input logic [NUM_CNT-1:0] ch);
    logic anyProbe;
    logic pRes;
    logic cRes;
    logic res;
    anyProbe = |cd.cmpMask;
    pRes = cd.probeAnd ? &(hit | ~cd.cmpMask)
                       : |(hit & cd.cmpMask);
    cRes = ch[cd.cntSel];
    if (!cd.cntEn)
      res = anyProbe & pRes;
    else if (!anyProbe)
      res = cRes;
    else
      res = cd.cntAnd ? (pRes & cRes) : (pRes | cRes);
    return res;
  endfunction
  function automatic logic [DAT_W-1:0] mergeSel(input logic [DAT_W-1:0] old,
                                                input logic [DAT_W-1:0] nw,
                                                input logic [SEL_W-1:0] sel,
                                                input logic [DAT_W-1:0] msk);
    logic [DAT_W-1:0] res;
    res = old;
    for (int b = 0; b < SEL_W; b++)
      if (sel[b])
        res[b*8 +: 8] = nw[b*8 +: 8];
    return res & msk;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // branch decision of the current state
  always_comb
  begin
    curCond  = cond_word_t'(condMem[seqState]);
    cond1Hit = evalCond(curCond.cond1, cmpHit, cntHit);
    cond2Hit = evalCond(curCond.cond2, cmpHit, cntHit);
    case (curCond.branch)
      BR_TWO:   blkSel = cond1Hit ? 2'h0 : 2'h1;
      BR_THREE: blkSel = cond1Hit ? 2'h0 :
                         (cond2Hit ? 2'h1 : 2'h2);
      default:  blkSel = 2'h0;
    endcase
    curAct = action_t'(actMem[seqState][blkSel][ACT_W-1:0]);
  end
  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: ack one cycle after the request, write on the ack edge
  always_comb
  begin
    next_condMem   = condMem;
    next_actMem    = actMem;
    next_pcmpMem   = pcmpMem;
    next_cntCmpMem = cntCmpMem;
    next_wbRsp.ack = wbReq.cyc & wbReq.stb & ~wbRsp.ack;
    next_wbRsp.dat = wbRsp.dat;
    wrEn    = wbReq.cyc & wbReq.stb & wbReq.we & wbRsp.ack;
    armCmd  = 1'b0;
    stopCmd = 1'b0;
    rdWord  = '0;
    if (wbReq.adr == CTRL_OFS)
    begin
      armCmd  = wrEn & wbReq.sel[0] & wbReq.dat[CTRL_ARM_BIT];
      stopCmd = wrEn & wbReq.sel[0] & wbReq.dat[CTRL_STOP_BIT];
    end
    else if (wbReq.adr == STATUS_OFS)
    begin
      rdWord[STAT_STATE_LSB +: STATE_W] = seqState;
      rdWord[STAT_FLAG_LSB +: NUM_FLAGS] = statusFlags;
      rdWord[STAT_RUN_BIT]  = running;
      rdWord[STAT_TRIG_BIT] = triggered;
    end
    else if (wbReq.adr[ADR_W-1:4] == CNT_VAL_BASE[ADR_W-1:4])
      rdWord[CNT_W-1:0] = counters[wbReq.adr[3:2]];
    else if (wbReq.adr[ADR_W-1:4] == CNT_CMP_BASE[ADR_W-1:4])
    begin
      rdWord = cntCmpMem[wbReq.adr[3:2]];
      if (wrEn)
        next_cntCmpMem[wbReq.adr[3:2]] = mergeSel(rdWord, wbReq.dat,
                                           wbReq.sel, CNTCMP_WMASK);
    end
    else if (wbReq.adr[ADR_W-1:8] == PCMP_BASE[ADR_W-1:8] &&
             int'(wbReq.adr[7:3]) < NUM_CMP)
    begin
      rdWord = pcmpMem[wbReq.adr[5:3]][wbReq.adr[2]];
      if (wrEn)
        next_pcmpMem[wbReq.adr[5:3]][wbReq.adr[2]] =
          mergeSel(rdWord, wbReq.dat, wbReq.sel,
                   wbReq.adr[2] ? PCMP1_WMASK : PCMP0_WMASK);
    end
    else if (wbReq.adr[ADR_W-1:8] == PROG_BASE[ADR_W-1:8])
    begin
      if (wbReq.adr[3:2] == 2'h0)
      begin
        rdWord = condMem[wbReq.adr[7:4]];
        if (wrEn)
          next_condMem[wbReq.adr[7:4]] = mergeSel(rdWord, wbReq.dat,
                                           wbReq.sel, COND_WMASK);
      end
      else
      begin
        rdWord = actMem[wbReq.adr[7:4]][wbReq.adr[3:2] - 2'h1];
        if (wrEn)
          next_actMem[wbReq.adr[7:4]][wbReq.adr[3:2] - 2'h1] =
            mergeSel(rdWord, wbReq.dat, wbReq.sel, ACT_WMASK);
      end
    end
    if (next_wbRsp.ack && !wbReq.we)
      next_wbRsp.dat = rdWord;
  end
  ////////////////////////////////////////////////////////////////////////////
  // sequencer step
  always_comb
  begin
    next_seq         = seq;
    next_seqState    = seqState;
    next_counters    = counters;
    next_statusFlags = statusFlags;
    next_trigger     = 1'b0;
    next_triggered   = triggered;
    stepEn           = 1'b0;
    if (stopCmd)
      next_seq = SEQ_IDLE;
    else if (armCmd)
    begin
      next_seq         = SEQ_ARMED;
      next_seqState    = '0;
      next_counters    = '{default: '0};
      next_statusFlags = '0;
      next_triggered   = 1'b0;
    end
    else if (seq == SEQ_ARMED)
    begin
      stepEn = 1'b1;
      next_statusFlags = (statusFlags & ~curAct.clrFlag)
                         | curAct.setFlag;
      for (int k = 0; k < NUM_CNT; k++)
        if (curAct.rstCnt[k])
          next_counters[k] = '0;
        else if (curAct.incCnt[k])
          next_counters[k] = counters[k] + 16'h0001;
      if (curAct.trig)
      begin
        next_trigger   = 1'b1;
        next_triggered = 1'b1;
        next_seq       = SEQ_DONE;
      end
      else
        next_seqState = curAct.target;
    end
    next_running = (next_seq == SEQ_ARMED);
  end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      condMem     <= '{default: MEM_RST};
      actMem      <= '{default: '{default: MEM_RST}};
      pcmpMem     <= '{default: '{default: MEM_RST}};
      cntCmpMem   <= '{default: MEM_RST};
      counters    <= '{default: '0};
      wbRsp       <= '0;
      seq         <= SEQ_IDLE;
      seqState    <= '0;
      statusFlags <= '0;
      trigger     <= 1'b0;
      running     <= 1'b0;
      triggered   <= 1'b0;
      probePrev   <= '0;
    end
    else
    begin
      condMem     <= next_condMem;
      actMem      <= next_actMem;
      pcmpMem     <= next_pcmpMem;
      cntCmpMem   <= next_cntCmpMem;
      counters    <= next_counters;
      wbRsp       <= next_wbRsp;
      seq         <= next_seq;
      seqState    <= next_seqState;
      statusFlags <= next_statusFlags;
      trigger     <= next_trigger;
      running     <= next_running;
      triggered   <= next_triggered;
      probePrev   <= probes;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  trig_once_a: assert property (trigger |=> !trigger)
    else $error("trigger held longer than one cycle");
  cnt_clear_a: assert property (stepEn && curAct.rstCnt[0] |=>
    counters[0] == 16'h0000)
    else $error("counter zero not cleared");
  cnt_inc_a: assert property (stepEn && curAct.incCnt[1] &&
    !curAct.rstCnt[1] |=> counters[1] == $past(counters[1]) + 16'h0001)
    else $error("counter one did not count up");
  flag_set_a: assert property (stepEn && curAct.setFlag[2]
    |=> statusFlags[2])
    else $error("flag two not set");
  flag_clr_a: assert property (stepEn && curAct.clrFlag[3] &&
    !curAct.setFlag[3] |=> !statusFlags[3])
    else $error("flag three not cleared");
  goto_step_a: assert property (stepEn && !curAct.trig |=>
    seqState == $past(curAct.target) && running)
    else $error("goto did not reach target");
  one_way_a: assert property (stepEn && curCond.branch == BR_ONE
    |-> blkSel == 2'h0)
    else $error("one-way branch took a conditional block");
  two_way_a: assert property (stepEn && curCond.branch == BR_TWO
    |-> blkSel == (cond1Hit ? 2'h0 : 2'h1))
    else $error("two-way branch chose wrong block");
  three_way_a: assert property (stepEn &&
    curCond.branch == BR_THREE && !cond1Hit
    |-> blkSel == (cond2Hit ? 2'h1 : 2'h2))
    else $error("three-way branch chose wrong block");
  trig_stop_a: assert property (trigger |-> triggered && !running
    && $past(running))
    else $error("trigger without a running sequencer");
  bus_ack_a: assert property (wbReq.cyc && wbReq.stb && !wbRsp.ack
    |=> wbRsp.ack ##1 !wbRsp.ack)
    else $error("wishbone ack not a single cycle after request");
endmodule

// ---- tb/probe_source.sv ----
// Purpose: stand-in for the user logic that drives the watched probes
// Assumes: user logic is synchronous to clk_sys
// Notes:   registers the value the bench asks for, so each probe value
//          lands one clock after it is requested, like a real flop output
module probe_source
#(
  parameter int WIDTH = 32
)(
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] nextVal,
  output      logic [WIDTH-1:0] probes
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      probes <= '0;
    else
      probes <= nextVal;
  end
endmodule

// ---- tb/tb.sv ----
// Purpose: self-checking bench of the trigger sequencer
// Assumes: one clock at 10 MHz, classic single-cycle bus master
// Notes:   reads queue their expected word; a monitor compares on ack
module tb import trig_seq_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys;
  logic        rstn;
  wb_req_t     wbReq;
  wb_rsp_t     wbRsp;
  logic [31:0] nextProbe;
  logic [31:0] probes;
  logic        trigger;
  logic [3:0]  statusFlags;
  logic [3:0]  seqState;
  logic        running;
  logic        triggered;
  int          errors = 0;
  int          n_compared = 0;
  int          trigCount = 0;
  int          expTrig = 0;
  logic [31:0] expQ[$];
  logic [11:0] adrQ[$];
  logic [7:0]  seed;
  logic [7:0]  pv;
  logic [7:0]  cv;
  logic [7:0]  care;
  logic        hit;
  logic [9:0]  pins;

  probe_source #(.WIDTH(32)) probe_u (.clk_sys(clk_sys), .rstn(rstn),
    .nextVal(nextProbe), .probes(probes));
  trigger_sequencer_fsm #(.NUM_PROBES(4), .PROBE_W(8), .CMP_PER_PROBE(2))
    dut_u (.clk_sys(clk_sys), .rstn(rstn), .wbReq(wbReq), .wbRsp(wbRsp),
    .probes(probes), .trigger(trigger), .statusFlags(statusFlags),
    .seqState(seqState), .running(running), .triggered(triggered));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic hit_of(input int op, input logic [7:0] p, v);
    case (op)
      0: return p == v;
      1: return p != v;
      2: return p > v;
      3: return p < v;
      4: return p >= v;
      default: return p <= v;
    endcase
  endfunction

  // the request stands until ack is seen at a rising edge, then drops
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
    do @(posedge clk_sys); while (wbRsp.ack !== 1'b1);
    wbReq <= '0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    expQ.push_back(e);
    adrQ.push_back(a);
    wb(1'b0, a, 32'h0);
  endtask

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // read data is taken only at the edge where ack is sampled high
  always @(posedge clk_sys)
  begin
    if (wbRsp.ack === 1'b1 && wbReq.we === 1'b0 && expQ.size() > 0)
    begin
      n_compared++;
      if (wbRsp.dat !== expQ[0])
      begin
        errors++;
        $display("Error reg %h expected %h seen %h", adrQ[0], expQ[0],
          wbRsp.dat);
      end
      if (adrQ[0] == STATUS_OFS)
      begin
        n_compared++;
        pins = {triggered, running, statusFlags, seqState};
        if (pins !== expQ[0][9:0])
        begin
          errors++;
          $display("Error status pins expected %h seen %h", expQ[0][9:0],
            pins);
        end
      end
      void'(expQ.pop_front());
      void'(adrQ.pop_front());
    end
    if (trigger === 1'b1)
      trigCount++;
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    finish_test;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    wbReq = '0;
    nextProbe = 32'h0;
    rstn = 1'b0;
    seed = 8'h30;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(STATUS_OFS, 32'h0);
    rd(12'h800, 32'h0);
    wb(1'b1, CNT_VAL_BASE, 32'h1234);
    rd(CNT_VAL_BASE, 32'h0);
    $display("test reset_map done");
    // one-way chain, then a trigger block that also updates flags
    wb(1'b1, 12'h404, 32'h2021);
    wb(1'b1, 12'h414, 32'h2310);
    wb(1'b1, CTRL_OFS, 32'h1);
    repeat (6) @(posedge clk_sys);
    rd(STATUS_OFS, 32'h281);
    rd(CNT_VAL_BASE, 32'h2);
    expTrig++;
    $display("test one_way done");
    // two-way on a value compare with random don't-care bits
    wb(1'b1, 12'h400, 32'h10000001);
    wb(1'b1, 12'h404, 32'h10);
    wb(1'b1, 12'h408, 32'h0);
    for (int op = 0; op < 6; op++)
    begin
      seed = lfsr(seed);
      pv = seed;
      seed = lfsr(seed);
      cv = pv ^ (seed & 8'h33);
      seed = lfsr(seed);
      care = seed;
      nextProbe <= {seed, seed, seed, pv};
      hit = hit_of(op, pv & care, cv & care);
      wb(1'b1, PCMP_BASE, {8'h00, care, 8'h00, cv});
      wb(1'b1, 12'h104, 32'(op));
      wb(1'b1, CTRL_OFS, 32'h1);
      repeat (4) @(posedge clk_sys);
      rd(STATUS_OFS, hit ? 32'h200 : 32'h100);
      expTrig += int'(hit);
      wb(1'b1, CTRL_OFS, 32'h2);
    end
    $display("test value_ops done");
    // edge modes, each started from a settled 0 and a settled 1
    for (int op = 6; op < 10; op++)
      for (int s = 0; s < 2; s++)
      begin
        nextProbe <= 32'(s);
        wb(1'b1, 12'h104, 32'(op));
        wb(1'b1, CTRL_OFS, 32'h1);
        repeat (2) @(posedge clk_sys);
        nextProbe <= 32'(1 - s);
        repeat (4) @(posedge clk_sys);
        hit = (op == 6) ? (s == 0) : (op == 7) ? (s == 1) : 1'b1;
        rd(STATUS_OFS, hit ? 32'h200 : 32'h100);
        expTrig += int'(hit);
        wb(1'b1, CTRL_OFS, 32'h2);
      end
    $display("test edge_ops done");
    // three-way: counter term first, always-true probe term second
    wb(1'b1, CNT_CMP_BASE, 32'h3);
    wb(1'b1, PCMP_BASE, 32'h0);
    wb(1'b1, 12'h104, 32'h0);
    wb(1'b1, 12'h400, 32'h20002200);
    wb(1'b1, 12'h404, 32'h10);
    wb(1'b1, 12'h408, 32'h2000);
    wb(1'b1, CTRL_OFS, 32'h1);
    repeat (8) @(posedge clk_sys);
    rd(CNT_VAL_BASE, 32'h3);
    rd(STATUS_OFS, 32'h200);
    expTrig++;
    $display("test three_way done");
    // probe terms joined by AND, then AND with a not-equal counter term
    nextProbe <= 32'h0;
    wb(1'b1, CNT_CMP_BASE + 12'h4, 32'h10000);
    wb(1'b1, 12'h108, 32'h00ff005a);
    wb(1'b1, 12'h400, 32'h10001703);
    wb(1'b1, 12'h408, 32'h25080);
    wb(1'b1, CTRL_OFS, 32'h1);
    repeat (4) @(posedge clk_sys);
    rd(STATUS_OFS, 32'h140);
    nextProbe <= 32'h5a;
    repeat (4) @(posedge clk_sys);
    rd(STATUS_OFS, 32'h240);
    expTrig++;
    $display("test and_join done");
    n_compared++;
    if (trigCount != expTrig)
    begin
      errors++;
      $display("Error trigger pulses expected %0d seen %0d", expTrig,
        trigCount);
    end
    finish_test;
  end
endmodule
